/* core/spio_pkg.sv */
// Shared constants and carrier types for the shared-pin parallel I/O block
package spio_pkg;
	localparam int NUM_PORTS = 7;
	localparam int PORT_W = 8;
	localparam int NUM_PINS = NUM_PORTS * PORT_W;

	// Port numbers as seen on the register access port
	localparam logic [2:0] PORT_A = 3'h0;
	localparam logic [2:0] PORT_B = 3'h1;
	localparam logic [2:0] PORT_C = 3'h2;
	localparam logic [2:0] PORT_D = 3'h3;
	localparam logic [2:0] PORT_E = 3'h4;
	localparam logic [2:0] PORT_F = 3'h5;
	localparam logic [2:0] PORT_G = 3'h6;

	// Flat pin positions of the shared functions
	localparam int PIN_A0 = 0 * PORT_W;
	localparam int PIN_B0 = 1 * PORT_W;
	localparam int PIN_SER_TX = 2 * PORT_W + 0;
	localparam int PIN_SER_RX = 2 * PORT_W + 1;
	localparam int PIN_TW_DATA = 2 * PORT_W + 2;
	localparam int PIN_TW_CLK = 2 * PORT_W + 3;
	localparam int PIN_T1_CH0 = 3 * PORT_W + 0;
	localparam int PIN_T2_CH0 = 3 * PORT_W + 3;
	localparam int PIN_OUT_ONLY = 6 * PORT_W + 0;
	localparam int T1_CHANS = 3;
	localparam int T2_CHANS = 5;

	// Register kinds on the register access port
	localparam logic [1:0] KIND_DATA = 2'h0;
	localparam logic [1:0] KIND_DIR = 2'h1;
	localparam logic [1:0] KIND_PULL = 2'h2;
	localparam logic [1:0] KIND_SLEW = 2'h3;

	// Reset values
	localparam logic [7:0] RST_DATA = 8'h00;
	localparam logic [7:0] RST_DIR = 8'h00;
	localparam logic [7:0] RST_PULL = 8'h00;
	localparam logic [7:0] RST_SLEW = 8'h00;
	localparam logic RST_BKGD_EN = 1'b1;

	// Peripheral side signals that claim pins
	typedef struct packed {
		logic [7:0] kbi_pin_en;
		logic adc_en;
		logic [7:0] adc_pin_en;
		logic ser_en;
		logic ser_tx;
		logic tw_en;
		logic tw_data_out;
		logic tw_data_oe;
		logic tw_clk_out;
		logic tw_clk_oe;
		logic t1_en;
		logic t1_ext_clk;
		logic [T1_CHANS-1:0] t1_out;
		logic [T1_CHANS-1:0] t1_oe;
		logic t2_en;
		logic t2_ext_clk;
		logic [T2_CHANS-1:0] t2_out;
		logic [T2_CHANS-1:0] t2_oe;
		logic bkgd_out;
		logic bkgd_oe;
	} spio_per_s;

	// Per-pin drive request from the ownership decode
	typedef struct packed {
		logic own;
		logic out;
		logic oe;
		logic pull_force;
	} spio_claim_s;

	// Pin side result of one pin multiplexer
	typedef struct packed {
		logic out;
		logic drive;
		logic pull;
		logic slew;
	} spio_pad_s;
endpackage : spio_pkg

/* core/spio_sync.sv */
// Three-stage input synchroniser with agreement filter
`timescale 1ns/1ps
`default_nettype none
module spio_sync #(
	parameter int W = 8
) (
	input wire logic ref_clk_in,
	input wire logic sys_rst_in,
	input wire logic [W-1:0] d_in,
	output logic [W-1:0] q_out
);
	typedef struct packed {
		logic [W-1:0] s1;
		logic [W-1:0] s2;
		logic [W-1:0] s3;
		logic [W-1:0] lvl;
	} spio_sync_state_s;

	spio_sync_state_s st_r;
	spio_sync_state_s st_nxt;

	// Level moves only when stages two and three agree; stage one feeds s2 only
	always_comb begin
		st_nxt = st_r;
		st_nxt.s1 = d_in;
		st_nxt.s2 = st_r.s1;
		st_nxt.s3 = st_r.s2;
		for (int i = 0; i < W; i++) begin
			if (st_r.s2[i] == st_r.s3[i]) begin
				st_nxt.lvl[i] = st_r.s3[i];
			end
		end
	end

	always_ff @(posedge ref_clk_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			st_r <= '0;
		end else begin
			st_r <= st_nxt;
		end
	end

	assign q_out = st_r.lvl;
endmodule : spio_sync
`default_nettype wire

/* core/spio_pin_mux.sv */
// One pin's choice between peripheral and general-purpose control
`timescale 1ns/1ps
`default_nettype none
module spio_pin_mux (
	input wire logic gp_data_in,
	input wire logic gp_dir_in,
	input wire logic gp_pull_in,
	input wire logic gp_slew_in,
	input wire spio_pkg::spio_claim_s claim_in,
	output spio_pkg::spio_pad_s pad_out
);
	// Peripheral wins; pull-up acts on a driven pin only when the claim forces it
	always_comb begin
		if (claim_in.own) begin
			pad_out.out = claim_in.out;
			pad_out.drive = claim_in.oe;
			pad_out.pull = claim_in.pull_force |
				(gp_pull_in & ~gp_dir_in & ~claim_in.oe);
			pad_out.slew = gp_slew_in & claim_in.oe;
		end else begin
			pad_out.out = gp_data_in;
			pad_out.drive = gp_dir_in;
			pad_out.pull = gp_pull_in & ~gp_dir_in;
			pad_out.slew = gp_slew_in & gp_dir_in;
		end
	end
endmodule : spio_pin_mux
`default_nettype wire

/* core/spio_top.sv */
// Seven-port parallel I/O with peripheral pin sharing
// Behaviour
// - 56 pins in seven ports; one output-only
// - Data, direction, pull-up, slew per pin
// - Unclaimed pins return to general-purpose control
// - Reset clears direction and pull-up bits
// - Background function owns its pin after reset
// - Keyboard-enabled port A pins forced to inputs
// - Analog-enabled port B pins forced to inputs
// - Analog pin enables pick converter pins
// - Serial or two-wire port sets port C direction
// - Serial transmit on C0, receive on C1
// - Two-wire data on C2, clock on C3
// - Enabled timers set their port D directions
// - Second timer on D7-D3, clock on D3
// - First timer on D2-D0, clock on D0
// - Data read gives pin when input, latch when output
// - Data writes always update the output latch
// - Direction bit picks read source despite overrides
`timescale 1ns/1ps
`default_nettype none
module spio_top (
	input wire logic ref_clk_in,
	input wire logic sys_rst_in,
	// Register write port, one strobe per byte
	input wire logic reg_wr_in,
	input wire logic [2:0] reg_port_in,
	input wire logic [1:0] reg_kind_in,
	input wire logic [7:0] reg_wdata_in,
	// Port whose data register is read back
	input wire logic [2:0] rd_port_in,
	// System options write for the background pin enable
	input wire logic sys_opt_wr_in,
	input wire logic background_pin_enable_in,
	// Peripheral requests on this clock, raw pad levels from outside
	input wire spio_pkg::spio_per_s per_in,
	input wire logic [spio_pkg::NUM_PINS-1:0] pin_in,
	// Read-back word and option bit
	output logic [7:0] rd_data_out,
	output logic background_pin_enable_out,
	// Pad controls; an oe_n bit is low while the pin is driven
	output logic [spio_pkg::NUM_PINS-1:0] pin_out,
	output logic [spio_pkg::NUM_PINS-1:0] pin_oe_n_out,
	output logic [spio_pkg::NUM_PINS-1:0] pin_pull_up_out,
	output logic [spio_pkg::NUM_PINS-1:0] pin_slew_out,
	output logic [spio_pkg::NUM_PINS-1:0] pin_level_out
);
	// Short names for the port and pin counts
	localparam int NP = spio_pkg::NUM_PORTS;
	localparam int NPIN = spio_pkg::NUM_PINS;

	typedef struct packed {
		// Software control registers, one byte per port
		logic [NP-1:0][7:0] port_data_reg;
		logic [NP-1:0][7:0] port_direction_reg;
		logic [NP-1:0][7:0] port_pull_up_enable_reg;
		logic [NP-1:0][7:0] port_slew_control_reg;
		// Background function holds pin G0 while set
		logic background_pin_enable;
		// Read-back word, one cycle behind rd_port_in
		logic [7:0] rd_data;
		// Pad image, flopped so no mux glitch reaches a pin
		logic [NPIN-1:0] pad_out;
		logic [NPIN-1:0] pad_oe_n;
		logic [NPIN-1:0] pad_pull;
		logic [NPIN-1:0] pad_slew;
	} spio_state_s;

	spio_state_s st_r;
	spio_state_s st_nxt;
	// Per-pin claims and the mux results they produce
	spio_pkg::spio_claim_s [NPIN-1:0] claim;
	spio_pkg::spio_pad_s [NPIN-1:0] pad;
	// Control bits flattened to pin order
	logic [NPIN-1:0] gp_data;
	logic [NPIN-1:0] gp_dir;
	logic [NPIN-1:0] gp_pull;
	logic [NPIN-1:0] gp_slew;
	// Filtered pad levels after the synchroniser
	logic [NPIN-1:0] level;
	// Read word of every port, picked by rd_port_in
	logic [NP-1:0][7:0] rd_word;

	// Pin levels come from outside the clock domain
	// Three stages keep a metastable pad away from the read path
	spio_sync #(
		.W(NPIN)
	) u_sync (
		.ref_clk_in(ref_clk_in),
		.sys_rst_in(sys_rst_in),
		.d_in(pin_in),
		.q_out(level)
	);

	// Flatten the per-port control registers into pin order
	// Packed arrays already hold port A in the low byte
	assign gp_data = st_r.port_data_reg;
	assign gp_dir = st_r.port_direction_reg;
	assign gp_pull = st_r.port_pull_up_enable_reg;
	assign gp_slew = st_r.port_slew_control_reg;

	// Read words per port; the direction bit picks latch or pin level even
	// while a peripheral owns the pin, so software sees what it wrote
	for (genvar q = 0; q < NP; q++) begin : g_rd
		logic [7:0] lvl_q;
		logic [7:0] dir_q;
		logic [7:0] lat_q;
		assign dir_q = st_r.port_direction_reg[q];
		assign lat_q = st_r.port_data_reg[q];
		if (q == int'(spio_pkg::PORT_G)) begin : g_out_only
			// Output-only pin has no input path: it reads its latch
			assign lvl_q = {level[q * 8 + 1 +: 7], lat_q[0]};
		end else begin : g_plain
			assign lvl_q = level[q * 8 +: 8];
		end
		// Driven bits give the latch, sensed bits the pin level
		assign rd_word[q] = (dir_q & lat_q) | (~dir_q & lvl_q);
	end

	// Ownership decode: which peripheral claims which pin, and how
	// Later sections win, which sets the priority between peripherals
	always_comb begin
		claim = '0;
		// Keyboard inputs are forced to inputs
		// A claim with oe low overrides the direction bit for drive; the bit still gates the pull-up
		for (int i = 0; i < 8; i++) begin
			claim[spio_pkg::PIN_A0 + i].own = per_in.kbi_pin_en[i];
			claim[spio_pkg::PIN_A0 + i].oe = 1'b0;
		end

		// Converter pins only while the converter itself runs
		for (int i = 0; i < 8; i++) begin
			claim[spio_pkg::PIN_B0 + i].own =
				per_in.adc_en & per_in.adc_pin_en[i];
			claim[spio_pkg::PIN_B0 + i].oe = 1'b0;
		end

		// Serial port: transmit driven, receive input
		// Receive is claimed too, so a stray direction bit cannot fight it
		if (per_in.ser_en) begin
			claim[spio_pkg::PIN_SER_TX].own = 1'b1;
			claim[spio_pkg::PIN_SER_TX].out = per_in.ser_tx;
			claim[spio_pkg::PIN_SER_TX].oe = 1'b1;
			claim[spio_pkg::PIN_SER_RX].own = 1'b1;
			claim[spio_pkg::PIN_SER_RX].oe = 1'b0;
		end

		// Two-wire port steers both its pins itself
		// Each line is released by the module, never by the direction bit
		if (per_in.tw_en) begin
			claim[spio_pkg::PIN_TW_DATA].own = 1'b1;
			claim[spio_pkg::PIN_TW_DATA].out = per_in.tw_data_out;
			claim[spio_pkg::PIN_TW_DATA].oe = per_in.tw_data_oe;
			claim[spio_pkg::PIN_TW_CLK].own = 1'b1;
			claim[spio_pkg::PIN_TW_CLK].out = per_in.tw_clk_out;
			claim[spio_pkg::PIN_TW_CLK].oe = per_in.tw_clk_oe;
		end

		// First timer channels on D2..D0
		// The timer gives its own enable per channel
		for (int i = 0; i < spio_pkg::T1_CHANS; i++) begin
			if (per_in.t1_en) begin
				claim[spio_pkg::PIN_T1_CH0 + i].own = 1'b1;
				claim[spio_pkg::PIN_T1_CH0 + i].out = per_in.t1_out[i];
				claim[spio_pkg::PIN_T1_CH0 + i].oe = per_in.t1_oe[i];
			end
		end
		// External clock only on the lowest channel pin, always input
		if (per_in.t1_ext_clk) begin
			claim[spio_pkg::PIN_T1_CH0].own = 1'b1;
			claim[spio_pkg::PIN_T1_CH0].oe = 1'b0;
		end

		// Second timer channels on D7..D3
		for (int i = 0; i < spio_pkg::T2_CHANS; i++) begin
			if (per_in.t2_en) begin
				claim[spio_pkg::PIN_T2_CH0 + i].own = 1'b1;
				claim[spio_pkg::PIN_T2_CH0 + i].out = per_in.t2_out[i];
				claim[spio_pkg::PIN_T2_CH0 + i].oe = per_in.t2_oe[i];
			end
		end
		// External clock only on D3, always input
		if (per_in.t2_ext_clk) begin
			claim[spio_pkg::PIN_T2_CH0].own = 1'b1;
			claim[spio_pkg::PIN_T2_CH0].oe = 1'b0;
		end

		// Background function holds its pin with pull-up on
		// Pull-up keeps an unattached mode pin from floating
		if (st_r.background_pin_enable) begin
			claim[spio_pkg::PIN_OUT_ONLY].own = 1'b1;
			claim[spio_pkg::PIN_OUT_ONLY].out = per_in.bkgd_out;
			claim[spio_pkg::PIN_OUT_ONLY].oe = per_in.bkgd_oe;
			claim[spio_pkg::PIN_OUT_ONLY].pull_force = 1'b1;
		end
	end

	// One multiplexer per pin
	// Each mux is pure logic; the flops sit after it
	for (genvar p = 0; p < NPIN; p++) begin : g_pin
		spio_pin_mux u_mux (
			.gp_data_in(gp_data[p]),
			.gp_dir_in(gp_dir[p]),
			.gp_pull_in(gp_pull[p]),
			.gp_slew_in(gp_slew[p]),
			.claim_in(claim[p]),
			.pad_out(pad[p])
		);
	end

	// Register writes, read mux and registered pad drive
	always_comb begin
		// Hold everything unless a write or a read changes it
		st_nxt = st_r;
		// Data latch takes every write, owned or input alike
		// Writes to port 7 fall through and change nothing
		if (reg_wr_in && reg_port_in < 3'(NP)) begin
			case (reg_kind_in)
				spio_pkg::KIND_DATA: begin
					st_nxt.port_data_reg[reg_port_in] = reg_wdata_in;
				end
				spio_pkg::KIND_DIR: begin
					st_nxt.port_direction_reg[reg_port_in] = reg_wdata_in;
				end
				spio_pkg::KIND_PULL: begin
					st_nxt.port_pull_up_enable_reg[reg_port_in] = reg_wdata_in;
				end
				spio_pkg::KIND_SLEW: begin
					st_nxt.port_slew_control_reg[reg_port_in] = reg_wdata_in;
				end
				default: begin
					st_nxt.rd_data = st_r.rd_data;
				end
			endcase
		end

		// Plain rewritable bit, so software may hand the pin back
		if (sys_opt_wr_in) begin
			st_nxt.background_pin_enable = background_pin_enable_in;
		end

		// Read source follows the direction bit, not the real pin direction
		if (rd_port_in < 3'(NP)) begin
			st_nxt.rd_data = rd_word[rd_port_in];
		end else begin
			st_nxt.rd_data = 8'h00;
		end

		// Drive is registered so every pin output comes from a flop
		for (int p = 0; p < NPIN; p++) begin
			st_nxt.pad_out[p] = pad[p].out;
			st_nxt.pad_oe_n[p] = ~pad[p].drive;
		end
		// Pull-up and slew per pin, flopped the same way
		for (int p = 0; p < NPIN; p++) begin
			st_nxt.pad_pull[p] = pad[p].pull;
			st_nxt.pad_slew[p] = pad[p].slew;
		end
		// Output-only pin never takes a general-purpose pull-up
		if (!st_r.background_pin_enable) begin
			st_nxt.pad_pull[spio_pkg::PIN_OUT_ONLY] = 1'b0;
		end
	end

	// All pins come up as undriven inputs with all pull-ups off; G0 pull-up comes on at the first clock after reset
	always_ff @(posedge ref_clk_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			// Control registers clear; background owns its pin
			st_r.port_data_reg <= {NP{spio_pkg::RST_DATA}};
			st_r.port_direction_reg <= {NP{spio_pkg::RST_DIR}};
			st_r.port_pull_up_enable_reg <= {NP{spio_pkg::RST_PULL}};
			st_r.port_slew_control_reg <= {NP{spio_pkg::RST_SLEW}};
			st_r.background_pin_enable <= spio_pkg::RST_BKGD_EN;
			st_r.rd_data <= 8'h00;
			// Pad image of an idle, undriven pin
			st_r.pad_out <= '0;
			st_r.pad_oe_n <= '1;
			st_r.pad_pull <= '0;
			st_r.pad_slew <= '0;
		end else begin
			st_r <= st_nxt;
		end
	end

	// Ports are plain views of the state flops
	assign rd_data_out = st_r.rd_data;
	assign background_pin_enable_out = st_r.background_pin_enable;
	assign pin_out = st_r.pad_out;
	assign pin_oe_n_out = st_r.pad_oe_n;
	assign pin_pull_up_out = st_r.pad_pull;
	assign pin_slew_out = st_r.pad_slew;
	assign pin_level_out = level;
endmodule : spio_top
`default_nettype wire

/* verification/spio_pads_model.sv */
// Board-side pad model for the shared-pin I/O block
`timescale 1ns/1ps
`default_nettype none
module spio_pads_model (
	input wire logic ref_clk_in,
	input wire logic [55:0] drv_in,
	input wire logic [55:0] oe_n_in,
	input wire logic [55:0] pull_in,
	output logic [55:0] pad_out
);
	logic [55:0] float_r = 56'h0;
	// Floating pins wander, so a stale level never reads as valid
	always @(posedge ref_clk_in) begin
		float_r <= ~float_r;
	end
	// Pull-up matters only while nobody drives the pin
	assign pad_out = oe_n_in & (pull_in | float_r) | ~oe_n_in & drv_in;
endmodule : spio_pads_model
`default_nettype wire

/* verification/spio_top_properties.sv */
// Port-level assertions for the shared-pin I/O block
`timescale 1ns/1ps
`default_nettype none
module spio_top_properties (
	input wire logic ref_clk_in,
	input wire logic sys_rst_in,
	input wire spio_pkg::spio_per_s per_in,
	input wire logic background_pin_enable_out,
	input wire logic [55:0] pin_out,
	input wire logic [55:0] pin_oe_n_out,
	input wire logic [55:0] pin_pull_up_out
);
	default clocking cb @(posedge ref_clk_in);
	endclocking
	default disable iff (sys_rst_in);
	logic [55:0] drv;
	// Driven pins as a positive mask
	assign drv = ~pin_oe_n_out;
	rst_idle_a: assert property (disable iff (1'b0)
		sys_rst_in |-> drv == 56'h0 && pin_pull_up_out == 56'h0)
		else $error("pads active in reset");
	kbi_input_a: assert property (
		(drv[7:0] & $past(per_in.kbi_pin_en)) == 8'h00)
		else $error("keyboard pin driven");
	adc_input_a: assert property (
		$past(per_in.adc_en) |->
		(drv[15:8] & $past(per_in.adc_pin_en)) == 8'h00)
		else $error("analog pin driven");
	ser_pins_a: assert property (
		per_in.ser_en |=> drv[17:16] == 2'b01
		&& pin_out[16] == $past(per_in.ser_tx))
		else $error("serial pins wrong");
	tw_pins_a: assert property (
		$past(per_in.tw_en) |-> drv[19:18] ==
		{$past(per_in.tw_clk_oe), $past(per_in.tw_data_oe)})
		else $error("two-wire pins wrong");
	tmr_dir_a: assert property (
		$past(per_in.t1_en & ~per_in.t1_ext_clk & per_in.t2_en
		& ~per_in.t2_ext_clk) |->
		drv[31:24] == $past({per_in.t2_oe, per_in.t1_oe}))
		else $error("timer pins wrong");
	bg_pin_a: assert property (
		!$past(sys_rst_in) && $past(background_pin_enable_out) |->
		pin_pull_up_out[48] && drv[48] == $past(per_in.bkgd_oe))
		else $error("mode pin not owned");
	pull_in_a: assert property (
		(pin_pull_up_out[47:0] & drv[47:0]) == 48'h0)
		else $error("pull-up on driven pin");
	ser_c: cover property (per_in.ser_en ##2 drv[16]);
	tmr_c: cover property (per_in.t1_en && per_in.t2_en);
	bg_off_c: cover property ($fell(background_pin_enable_out));
endmodule : spio_top_properties
bind spio_top spio_top_properties chk (.*);
`default_nettype wire

/* verification/spio_top_test.sv */
// Self-checking bench for the shared-pin I/O block
`timescale 1ns/1ps
`default_nettype none
module spio_top_test;
	logic ref_clk_in = 1'b0;
	logic sys_rst_in = 1'b0;
	logic reg_wr_in = 1'b0;
	logic [2:0] reg_port_in = 3'h0;
	logic [1:0] reg_kind_in = 2'h0;
	logic [7:0] reg_wdata_in = 8'h00;
	logic [2:0] rd_port_in = 3'h0;
	logic sys_opt_wr_in = 1'b0;
	logic background_pin_enable_in = 1'b1;
	spio_pkg::spio_per_s per_in = '0;
	logic [55:0] pin_in, pin_out, pin_oe_n_out, pin_pull_up_out;
	logic [55:0] pin_slew_out, pin_level_out;
	logic [7:0] rd_data_out;
	logic background_pin_enable_out;
	int failures = 0;
	int checks_done = 0;
	spio_top DUT (.*);
	spio_pads_model pads (.ref_clk_in(ref_clk_in), .drv_in(pin_out),
		.oe_n_in(pin_oe_n_out), .pull_in(pin_pull_up_out), .pad_out(pin_in));
	// Free-running 100 MHz clock
	initial forever #5 ref_clk_in = ~ref_clk_in;
	task automatic w(input int n);
		repeat (n) @(posedge ref_clk_in);
		#1;
	endtask : w
	task automatic ck(input logic [63:0] g, input logic [63:0] e);
		checks_done++;
		if (g !== e) begin
			failures++;
			$display("FAIL t=%0t got %h exp %h", $time, g, e);
		end
	endtask : ck
	// One-cycle write strobe; the next edge passes before any new write
	task automatic wr(input logic [2:0] p, input logic [1:0] k,
		input logic [7:0] d);
		@(posedge ref_clk_in);
		reg_wr_in <= 1'b1;
		reg_port_in <= p;
		reg_kind_in <= k;
		reg_wdata_in <= d;
		@(posedge ref_clk_in);
		reg_wr_in <= 1'b0;
	endtask : wr
	task automatic t_gpio;
		wr(3'h5, spio_pkg::KIND_DATA, 8'ha5);
		wr(3'h5, spio_pkg::KIND_DIR, 8'h0f);
		wr(3'h5, spio_pkg::KIND_PULL, 8'hf0);
		wr(3'h5, spio_pkg::KIND_SLEW, 8'h3c);
		wr(3'h7, spio_pkg::KIND_DIR, 8'hff);
		rd_port_in <= 3'h5;
		w(8);
		ck({pin_oe_n_out[47:40], pin_out[43:40], pin_pull_up_out[47:40],
			pin_slew_out[47:40]}, {8'hf0, 4'h5, 8'hf0, 8'h0c});
		ck(rd_data_out, 8'hf5);
		$display("gpio test done");
	endtask : t_gpio
	task automatic t_share;
		wr(3'h0, spio_pkg::KIND_DATA, 8'h55);
		wr(3'h0, spio_pkg::KIND_DIR, 8'hff);
		wr(3'h1, spio_pkg::KIND_DIR, 8'hff);
		wr(3'h2, spio_pkg::KIND_PULL, 8'hff);
		rd_port_in <= 3'h0;
		@(posedge ref_clk_in);
		per_in.kbi_pin_en <= 8'h0f;
		per_in.adc_en <= 1'b1;
		per_in.adc_pin_en <= 8'hf0;
		per_in.ser_en <= 1'b1;
		per_in.ser_tx <= 1'b1;
		per_in.tw_en <= 1'b1;
		per_in.tw_data_oe <= 1'b1;
		w(6);
		ck({pin_oe_n_out[15:0], pin_out[7:4], rd_data_out},
			{8'hf0, 8'h0f, 4'h5, 8'h55});
		ck({pin_oe_n_out[19:16], pin_out[18], pin_out[16],
			pin_pull_up_out[19:16], pin_level_out[17]},
			{4'ha, 2'b01, 4'ha, 1'b1});
		@(posedge ref_clk_in);
		per_in.kbi_pin_en <= 8'h00;
		per_in.adc_en <= 1'b0;
		per_in.ser_en <= 1'b0;
		per_in.ser_tx <= 1'b0;
		per_in.tw_en <= 1'b0;
		per_in.tw_data_oe <= 1'b0;
		w(2);
		ck(pin_oe_n_out[15:0], 16'h0000);
		$display("sharing test done");
	endtask : t_share
	task automatic t_timer;
		@(posedge ref_clk_in);
		per_in.t1_en <= 1'b1;
		per_in.t1_oe <= 3'b110;
		per_in.t1_ext_clk <= 1'b1;
		per_in.t2_en <= 1'b1;
		per_in.t2_oe <= 5'h1f;
		per_in.t2_ext_clk <= 1'b1;
		w(2);
		ck(pin_oe_n_out[31:24], 8'h09);
		@(posedge ref_clk_in);
		per_in.t1_ext_clk <= 1'b0;
		per_in.t2_ext_clk <= 1'b0;
		w(2);
		ck(pin_oe_n_out[31:24], 8'h01);
		@(posedge ref_clk_in);
		per_in <= '0;
		$display("timer test done");
	endtask : t_timer
	task automatic t_mode_pin;
		wr(3'h6, spio_pkg::KIND_DATA, 8'h01);
		wr(3'h6, spio_pkg::KIND_DIR, 8'h01);
		rd_port_in <= 3'h6;
		w(2);
		ck({pin_oe_n_out[48], pin_pull_up_out[48], rd_data_out[0]},
			3'b111);
		@(posedge ref_clk_in);
		sys_opt_wr_in <= 1'b1;
		background_pin_enable_in <= 1'b0;
		@(posedge ref_clk_in);
		sys_opt_wr_in <= 1'b0;
		rd_port_in <= 3'h7;
		w(2);
		ck({pin_oe_n_out[48], pin_out[48], background_pin_enable_out,
			rd_data_out}, {3'b010, 8'h00});
		$display("mode pin test done");
	endtask : t_mode_pin
	task automatic stop_test;
		$display("checks %0d failures %0d", checks_done, failures);
		if (failures == 0 && checks_done > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask : stop_test
	// Main sequence: reset, then each scenario in turn
	initial begin
		@(posedge ref_clk_in);
		sys_rst_in <= 1'b1;
		repeat (4) @(posedge ref_clk_in);
		sys_rst_in <= 1'b0;
		w(2);
		ck({pin_oe_n_out, pin_pull_up_out[55:48]}, {56'hff_ffff_ffff_ffff,
			8'h01});
		t_gpio;
		t_share;
		t_timer;
		t_mode_pin;
		stop_test;
	end
	// Watchdog against a hung run
	initial begin
		#100000;
		failures++;
		stop_test;
	end
endmodule : spio_top_test
`default_nettype wire
